// File: rtl/hps_buf2.sv
`timescale 1ns/1ps
module hps_buf2 #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill and drain sides
  hps_stream_if.snk in_s,
  hps_stream_if.src out_s
);
  // Head always sits in slot 0 so the drain side sees flops directly
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0] occ;
  } hps_buf_state_type;

  hps_buf_state_type s_q;
  hps_buf_state_type s_d;
  logic push;
  logic pop;

  assign in_s.ready = ~s_q.occ[1];
  assign out_s.valid = s_q.occ[0];
  assign out_s.data = s_q.mem[0];
  assign push = in_s.valid & ~s_q.occ[1];
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.mem[0] = s_q.mem[1];
      s_d.occ = {1'b0, s_q.occ[1]};
    end
    if (push) begin
      if (s_d.occ[0]) begin
        s_d.mem[1] = in_s.data;
        s_d.occ[1] = 1'b1;
      end else begin
        s_d.mem[0] = in_s.data;
        s_d.occ[0] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  no_lost_word_a: assert property (push && !pop |=> out_s.valid)
    else $error("pushed word not visible at drain side");
  full_refuse_a: assert property (s_q.occ[1] && !pop |=> s_q.occ[1] && $stable(s_q.mem))
    else $error("full buffer changed without drain");
endmodule

// File: rtl/hps_host_port.sv
`timescale 1ns/1ps
module hps_host_port
  import hps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Interface straps and 6800 form select (1: latch on chip select rise)
  input wire logic iface_strap_bit0,
  input wire logic iface_strap_bit1,
  input wire logic iface_strap_bit2,
  input wire logic form_cs_latch,
  // 6800 control pins
  input wire logic cs_n,
  input wire logic e_strobe,
  input wire logic rw_select,
  input wire logic cmd_data_select,
  // Data pads
  input wire logic [HPS_BUS_W-1:0] data_in,
  output logic [HPS_BUS_W-1:0] data_out,
  output logic [HPS_BUS_W-1:0] data_oe_n,
  // Serial pads handed to the serial engines
  output logic ser_clk,
  output logic ser_data,
  output hps_mode_type iface_mode,
  // Write stream toward the controller
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [HPS_BUS_W-1:0] wr_byte,
  output logic wr_is_data,
  output logic wr_overrun,
  // Read requests and answers
  output logic rd_req,
  output logic rd_is_data,
  input wire logic [HPS_BUS_W-1:0] status_in,
  input wire logic rd_resp_valid,
  input wire logic [HPS_BUS_W-1:0] rd_resp_byte
);
  typedef struct packed {
    hps_mode_type mode;
    logic e_prev;
    logic cs_prev;
    logic [HPS_BUS_W-1:0] dout;
    logic [HPS_BUS_W-1:0] oe_n;
    logic [HPS_BUS_W-1:0] pipe;
    logic ser_clk;
    logic ser_data;
    logic rd_req;
    logic rd_is_data;
    logic push_valid;
    logic [HPS_ENTRY_W-1:0] push_data;
    logic overrun;
  } hps_state_type;

  hps_state_type s_q;
  hps_state_type s_d;
  logic is6800;
  logic strobe;
  logic read_on;

  hps_stream_if #(.W(HPS_ENTRY_W)) in_s ();
  hps_stream_if #(.W(HPS_ENTRY_W)) out_s ();

  // Host cannot be stalled, so a refused push is only flagged
  hps_buf2 #(.W(HPS_ENTRY_W)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_s(in_s),
    .out_s(out_s)
  );

  assign in_s.valid = s_q.push_valid;
  assign in_s.data = s_q.push_data;
  assign out_s.ready = wr_ready;

  assign is6800 = (s_q.mode == HPS_MODE_6800);
  // Both forms need the same levels while data is driven
  assign read_on = is6800 && !cs_n && e_strobe && rw_select;
  always_comb begin
    strobe = 1'b0;
    if (is6800) begin
      // The form select must stay put while the bus is busy, or stale edge history can fire
      if (form_cs_latch) begin
        strobe = !s_q.cs_prev && cs_n && e_strobe;
      end else begin
        strobe = s_q.e_prev && !e_strobe && !cs_n;
      end
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_req = 1'b0;
    s_d.push_valid = 1'b0;
    // Straps are sampled every cycle; a strap change during an access may lose it
    s_d.mode = hps_decode({iface_strap_bit2, iface_strap_bit1, iface_strap_bit0});
    s_d.e_prev = e_strobe;
    s_d.cs_prev = cs_n;
    if (strobe) begin
      if (rw_select) begin
        s_d.rd_req = 1'b1;
        s_d.rd_is_data = cmd_data_select;
      end else begin
        s_d.push_valid = 1'b1;
        s_d.push_data = {cmd_data_select, data_in};
      end
    end
    // Display reads return the byte fetched by the previous read
    if (rd_resp_valid) begin
      s_d.pipe = rd_resp_byte;
    end
    s_d.oe_n = read_on ? HPS_OE_ON : HPS_OE_OFF;
    s_d.dout = cmd_data_select ? s_q.pipe : status_in;
    s_d.ser_clk = hps_is_serial(s_q.mode) && data_in[0];
    s_d.ser_data = hps_is_serial(s_q.mode) && data_in[1];
    // Sticky until reset so the user can tell that the stream lost a word
    if (s_q.push_valid && !in_s.ready) begin
      s_d.overrun = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= HPS_MODE_NONE;
      // Idle levels, so a strobe already present is not taken as an edge
      s_q.e_prev <= 1'b0;
      s_q.cs_prev <= 1'b1;
      s_q.oe_n <= HPS_OE_OFF;
      s_q.pipe <= HPS_PIPE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.dout;
  assign data_oe_n = s_q.oe_n;
  assign ser_clk = s_q.ser_clk;
  assign ser_data = s_q.ser_data;
  assign iface_mode = s_q.mode;
  assign rd_req = s_q.rd_req;
  assign rd_is_data = s_q.rd_is_data;
  assign wr_valid = out_s.valid;
  assign wr_byte = out_s.data[HPS_BUS_W-1:0];
  assign wr_is_data = out_s.data[HPS_BUS_W];
  assign wr_overrun = s_q.overrun;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence f1_fall(logic rw);
    (e_strobe && !cs_n && !form_cs_latch)
    ##1 (is6800 && !e_strobe && !cs_n && !form_cs_latch && rw_select == rw);
  endsequence

  sequence f2_rise(logic rw);
    (!cs_n && form_cs_latch)
    ##1 (is6800 && cs_n && e_strobe && form_cs_latch && rw_select == rw);
  endsequence

  // Strap decode and pad reuse
  strap_decode_a: assert property (
    {iface_strap_bit2, iface_strap_bit1, iface_strap_bit0} == HPS_STRAP_6800
    |=> iface_mode == HPS_MODE_6800)
    else $error("6800 strap not decoded");
  serial_pads_a: assert property (
    hps_is_serial(s_q.mode) |=> data_oe_n == HPS_OE_OFF && ser_clk == $past(data_in[0]))
    else $error("serial mode pad use wrong");

  // Access capture in both forms
  f1_read_a: assert property (
    f1_fall(1'b1) |=> rd_req && rd_is_data == $past(cmd_data_select))
    else $error("form 1 read not completed");
  f1_write_a: assert property (
    f1_fall(1'b0) |=> s_q.push_valid && s_q.push_data == $past({cmd_data_select, data_in}))
    else $error("form 1 write not latched");
  f2_read_a: assert property (
    f2_rise(1'b1) |=> rd_req && rd_is_data == $past(cmd_data_select))
    else $error("form 2 read not completed");
  f2_write_a: assert property (
    f2_rise(1'b0) |=> s_q.push_valid && s_q.push_data == $past({cmd_data_select, data_in}))
    else $error("form 2 write not latched");

  // Pad drive during reads, read sources, serial pads and ignored accesses
  read_drive_a: assert property (
    read_on |=> data_oe_n == HPS_OE_ON ##1 (!$past(read_on) || data_oe_n == HPS_OE_ON))
    else $error("bus not driven during read");
  bus_release_a: assert property (
    !read_on |=> data_oe_n == HPS_OE_OFF)
    else $error("bus driven outside read");
  cs_ignore_a: assert property (
    is6800 && !form_cs_latch && cs_n |=> !rd_req && !s_q.push_valid)
    else $error("access taken with chip select high");
  status_path_a: assert property (
    !cmd_data_select |=> data_out == $past(status_in))
    else $error("status read wrong source");
  data_path_a: assert property (
    cmd_data_select |=> data_out == $past(s_q.pipe))
    else $error("display read wrong source");
  ser_data_a: assert property (
    hps_is_serial(s_q.mode) |=> ser_data == $past(data_in[1]))
    else $error("serial data pad not forwarded");
  ser_quiet_a: assert property (
    !hps_is_serial(s_q.mode) |=> !ser_clk && !ser_data)
    else $error("serial pads active in parallel mode");
  mode_ignore_a: assert property (
    !is6800 |=> !rd_req && !s_q.push_valid)
    else $error("access taken outside 6800 mode");

  // Write stream and overrun
  write_out_a: assert property (
    s_q.push_valid && in_s.ready |=> wr_valid)
    else $error("latched write not offered downstream");
  overrun_set_a: assert property (
    s_q.push_valid && !in_s.ready |=> wr_overrun)
    else $error("lost write not flagged");
  overrun_hold_a: assert property (
    wr_overrun |=> wr_overrun)
    else $error("overrun flag cleared without reset");
endmodule

// File: rtl/hps_pkg.sv
package hps_pkg;

  localparam int HPS_BUS_W = 8;
  localparam int HPS_ENTRY_W = HPS_BUS_W + 1;

  // Strap codes as {bit2, bit1, bit0}
  localparam logic [2:0] HPS_STRAP_6800 = 3'h4;
  localparam logic [2:0] HPS_STRAP_8080 = 3'h6;
  localparam logic [2:0] HPS_STRAP_SPI4 = 3'h0;
  localparam logic [2:0] HPS_STRAP_SPI3 = 3'h1;
  localparam logic [2:0] HPS_STRAP_I2C = 3'h2;

  localparam logic [HPS_BUS_W-1:0] HPS_OE_OFF = 8'hFF;
  localparam logic [HPS_BUS_W-1:0] HPS_OE_ON = 8'h00;
  localparam logic [HPS_BUS_W-1:0] HPS_PIPE_RST = 8'h00;

  typedef enum logic [2:0] {
    HPS_MODE_NONE,
    HPS_MODE_6800,
    HPS_MODE_8080,
    HPS_MODE_SPI4,
    HPS_MODE_SPI3,
    HPS_MODE_I2C
  } hps_mode_type;

  function automatic hps_mode_type hps_decode(input logic [2:0] strap);
    case (strap)
      HPS_STRAP_6800: hps_decode = HPS_MODE_6800;
      HPS_STRAP_8080: hps_decode = HPS_MODE_8080;
      HPS_STRAP_SPI4: hps_decode = HPS_MODE_SPI4;
      HPS_STRAP_SPI3: hps_decode = HPS_MODE_SPI3;
      HPS_STRAP_I2C: hps_decode = HPS_MODE_I2C;
      default: hps_decode = HPS_MODE_NONE;
    endcase
  endfunction

  function automatic logic hps_is_serial(input hps_mode_type m);
    hps_is_serial = (m == HPS_MODE_SPI4) || (m == HPS_MODE_SPI3) || (m == HPS_MODE_I2C);
  endfunction

endpackage

// File: rtl/hps_stream_if.sv
`timescale 1ns/1ps
interface hps_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: testbench/host_port_select_6800_bus_tb.sv
`timescale 1ns/1ps
module host_port_select_6800_bus_tb;
  import hps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = HPS_STRAP_6800;
  logic f2 = 1'b0;
  logic wr_ready = 1'b1;
  logic rd_resp_valid = 1'b0;
  logic [7:0] status_in = 8'h00, rd_resp_byte = 8'h00, pipe = HPS_PIPE_RST, exp_rd = 8'h00;
  logic cs_n, e_strobe, rw_select, cmd_data_select, ser_clk, ser_data, wr_valid, wr_is_data;
  logic wr_overrun, rd_req, rd_is_data, ser;
  logic [7:0] drv, data_in, data_out, data_oe_n, wr_byte;
  hps_mode_type iface_mode;
  logic [8:0] q[$];
  logic [2:0] straps[6] = '{HPS_STRAP_8080, HPS_STRAP_SPI4, HPS_STRAP_SPI3, HPS_STRAP_I2C,
    3'h7, HPS_STRAP_6800};
  hps_mode_type modes[6] = '{HPS_MODE_8080, HPS_MODE_SPI4, HPS_MODE_SPI3, HPS_MODE_I2C,
    HPS_MODE_NONE, HPS_MODE_6800};
  int fails = 0, tests_run = 0, n_rd = 0;

  always #5 clk = ~clk;
  assign data_in = (~data_oe_n & data_out) | (data_oe_n & drv);

  hps_host_port dut (.clk, .rst_n, .iface_strap_bit0(strap[0]), .iface_strap_bit1(strap[1]),
    .iface_strap_bit2(strap[2]), .form_cs_latch(f2), .cs_n, .e_strobe, .rw_select,
    .cmd_data_select, .data_in, .data_out, .data_oe_n, .ser_clk, .ser_data, .iface_mode,
    .wr_valid, .wr_ready, .wr_byte, .wr_is_data, .wr_overrun, .rd_req, .rd_is_data,
    .status_in, .rd_resp_valid, .rd_resp_byte);
  hps_host_model host (.clk, .cs_n, .e_strobe, .rw_select, .cmd_data_select, .drv);

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic acc(input logic sel, input logic rw, input logic cd, input logic keep);
    logic [7:0] b;
    int r0;
    logic on;
    b = 8'($urandom);
    r0 = n_rd;
    status_in = 8'($urandom);
    // First data read only sees the reset pipeline byte, hence the dummy
    exp_rd = cd ? pipe : status_in;
    // Outside 6800 mode the strobes must be ignored entirely
    on = sel && (strap == HPS_STRAP_6800);
    if (on && !rw && keep) q.push_back({cd, b});
    host.acc(f2, sel, rw, cd, b);
    chk(9'(n_rd - r0), {8'h00, on & rw});
  endtask

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) chk({wr_is_data, wr_byte}, q.pop_front());
    if (rd_req === 1'b1) n_rd++;
  end

  always @(negedge clk) begin
    if (data_oe_n === HPS_OE_ON) chk({1'b0, data_out}, {1'b0, exp_rd});
    if (rd_req === 1'b1) chk({8'h00, rd_is_data}, {8'h00, cmd_data_select});
    if (rd_req === 1'b1 && rd_is_data === 1'b1) begin
      rd_resp_byte = 8'($urandom);
      pipe = rd_resp_byte;
    end
    rd_resp_valid = rd_req & rd_is_data;
  end

  initial begin
    void'($urandom(71059));
    repeat (10) @(negedge clk);
    chk({iface_mode, data_oe_n[5:0]}, {HPS_MODE_NONE, 6'h3f});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      f2 = i[0];
      // Two stalled accesses in a row at most, so the buffer never overflows here
      wr_ready = i[1] | i[2];
      acc(i % 5 != 4, 1'($urandom), 1'($urandom), 1'b1);
    end
    chk({8'h00, wr_overrun}, 9'h000);
    chk(9'(q.size()), 9'h000);
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      strap = straps[i];
      host.idle_pads(8'($urandom));
      repeat (3) @(negedge clk);
      chk({iface_mode, data_oe_n[5:0]}, {modes[i], HPS_OE_OFF[5:0]});
      ser = modes[i] inside {HPS_MODE_SPI4, HPS_MODE_SPI3, HPS_MODE_I2C};
      chk({7'h00, ser_data, ser_clk}, {7'h00, ser ? data_in[1:0] : 2'b00});
      if (i == 0) acc(1'b1, 1'b1, 1'b0, 1'b0);
    end
    $display("test 2 done");
    wr_ready = 1'b0;
    for (int i = 0; i < 3; i++) acc(1'b1, 1'b0, 1'(i), i < 2);
    chk({8'h00, wr_overrun}, 9'h001);
    wr_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk(9'(q.size()), 9'h000);
    $display("test 3 done");
    summarize();
  end

  // About 390 cycles of work; some eighteen times that means a hang
  initial begin
    #70000;
    fails++;
    summarize();
  end
endmodule

// File: testbench/hps_host_model.sv
`timescale 1ns/1ps
module hps_host_model (
  // Clock
  input wire logic clk,
  // 6800 bus as the processor drives it
  output logic cs_n,
  output logic e_strobe,
  output logic rw_select,
  output logic cmd_data_select,
  output logic [7:0] drv
);
  initial begin
    cs_n = 1'b1;
    e_strobe = 1'b0;
    rw_select = 1'b1;
    cmd_data_select = 1'b0;
    drv = 8'h00;
  end

  // Pad levels while the bus is idle, for the serial pad checks
  task automatic idle_pads(input logic [7:0] v);
    drv = v;
  endtask

  // One access; sel low leaves chip select high so the strobe must be ignored
  task automatic acc(input logic f2, input logic sel, input logic rw, input logic cd,
    input logic [7:0] b);
    @(negedge clk);
    rw_select = rw;
    cmd_data_select = cd;
    // A released pad must not keep showing the last written byte
    drv = rw ? ~drv : b;
    e_strobe = 1'b1;
    cs_n = ~sel;
    repeat (3) @(negedge clk);
    if (f2) begin
      cs_n = 1'b1;
    end else begin
      e_strobe = 1'b0;
    end
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    e_strobe = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule
